// ==== logic/trs_cfg.svh ====
`ifndef TRS_CFG_SVH
`define TRS_CFG_SVH
// Notes on behaviour
// - A high PLL lock input means that PLL is locked; one input per PLL.
// - Each channel's select field picks which PLL lock its transmit sequence watches.
// - With a shared transmit sequence, one select value serves every channel.
// - With a shared transmit sequence, the select bus carries one field only.
// - Transmit reset sequence is held while that channel's transmit busy is high.
// - Receive reset sequence is held while that channel's receive busy is high.
// - A high data-lock input means that CDR is ready for incoming data.
// - With shared receive control, all data-lock inputs are ANDed into one.
// - Transmit digital reset holds on reset, busy, no first lock, auto lock loss.
// - Receive digital reset holds on reset, analog reset, busy, auto lock loss, tx ack.

// Register map, byte addresses on the Wishbone slave.
`define TRS_ADR_CTRL 8'h00
`define TRS_ADR_TX_STAT 8'h04
`define TRS_ADR_RX_STAT 8'h08
`define TRS_ADR_ACK_STAT 8'h0c
// Control register fields.
`define TRS_CTRL_SW_RST 0
`define TRS_CTRL_TX_MANUAL 1
`define TRS_CTRL_RX_MANUAL 2
`define TRS_CTRL_SEQ_EN 3
`define TRS_CTRL_RESET 32'h0000_0001
`define TRS_UNMAPPED_DATA 32'h0000_0000
// Timing, in ns, and derived cycle counts at 50 MHz.
`define TRS_CLK_NS 20
`define TRS_SYNC_STAGES 2
`define TRS_TX_ANA_NS 40
`define TRS_TX_DIG_NS 40
`define TRS_RX_ANA_NS 40
`define TRS_RX_DIG_NS 4000
`define TRS_CYC(ns) ((((ns) + `TRS_CLK_NS - 1) / `TRS_CLK_NS) < 1 ? 1 : \
  (((ns) + `TRS_CLK_NS - 1) / `TRS_CLK_NS))
`define TRS_READY_DLY 3
`endif

// ==== logic/trs_pkg.sv ====
package trs_pkg;
  typedef enum logic [1:0] {
    TRS_ST_HOLD = 2'b00,
    TRS_ST_COUNT = 2'b01,
    TRS_ST_READY = 2'b10
  } trs_state_t;

  // One channel's synchronised status, carried together.
  typedef struct packed {
    logic tx_busy;
    logic rx_busy;
    logic data_lock;
    logic tx_ana_ack;
    logic rx_ana_ack;
    logic tx_dig_ack;
    logic rx_dig_ack;
  } trs_chan_stat_t;
endpackage

// ==== logic/trs_seq.sv ====
`timescale 1ns/1ns
`include "trs_cfg.svh"
module trs_seq
  import trs_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int NUM_PLL = 2,
  parameter bit TX_SEP = 1'b1,
  parameter bit RX_SEP = 1'b1,
  parameter int TX_DIG_CYC = `TRS_CYC(`TRS_TX_DIG_NS),
  parameter int RX_DIG_CYC = `TRS_CYC(`TRS_RX_DIG_NS),
  parameter int SEL_W = (NUM_PLL > 1) ? $clog2(NUM_PLL) : 1,
  parameter int SEL_N = TX_SEP ? NUM_CH : 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // PLL status.
  input wire logic [NUM_PLL-1:0] pll_locked,
  input wire logic [NUM_PLL-1:0] pll_cal_busy,
  input wire logic [SEL_N*SEL_W-1:0] pll_select,
  // Channel status from the PHY.
  input wire logic [NUM_CH-1:0] tx_cal_busy,
  input wire logic [NUM_CH-1:0] rx_cal_busy,
  input wire logic [NUM_CH-1:0] cdr_data_lock_in,
  input wire logic [NUM_CH-1:0] tx_analogreset_stat,
  input wire logic [NUM_CH-1:0] rx_analogreset_stat,
  input wire logic [NUM_CH-1:0] tx_digitalreset_stat,
  input wire logic [NUM_CH-1:0] rx_digitalreset_stat,
  // Resets and ready flags to the PHY.
  output logic [NUM_CH-1:0] tx_analogreset,
  output logic [NUM_CH-1:0] tx_digitalreset,
  output logic [NUM_CH-1:0] rx_analogreset,
  output logic [NUM_CH-1:0] rx_digitalreset,
  output logic [NUM_CH-1:0] tx_ready,
  output logic [NUM_CH-1:0] rx_ready
);
  localparam int SW = 2*NUM_PLL + 7*NUM_CH;
  localparam int CW = 16;

  initial begin
    if (NUM_CH < 1 || NUM_CH > 8 || NUM_PLL < 1 || NUM_PLL > 8)
      $error("trs_seq: channel and PLL counts must lie in 1..8");
    if (TX_DIG_CYC >= (1 << CW) || RX_DIG_CYC >= (1 << CW) || TX_DIG_CYC < 1)
      $error("trs_seq: reset durations do not fit the counters");
  end

  // Two-stage synchronisers; the first stage feeds only the second.
  logic [SW-1:0] meta_ff;
  logic [SW-1:0] sync_ff;
  wire [SW-1:0] raw_stat = {pll_locked, pll_cal_busy, tx_cal_busy, rx_cal_busy,
    cdr_data_lock_in, tx_analogreset_stat, rx_analogreset_stat,
    tx_digitalreset_stat, rx_digitalreset_stat};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_stat;
      sync_ff <= meta_ff;
    end
  end

  wire [NUM_PLL-1:0] s_lock = sync_ff[SW-1 -: NUM_PLL];
  wire [NUM_PLL-1:0] s_pbusy = sync_ff[SW-NUM_PLL-1 -: NUM_PLL];
  wire any_pll_busy = |s_pbusy;
  trs_chan_stat_t cs [NUM_CH];

  // Control register.
  logic [31:0] ctrl_ff;
  logic ack_ff;
  wire sw_rst = ctrl_ff[`TRS_CTRL_SW_RST];
  wire tx_manual = ctrl_ff[`TRS_CTRL_TX_MANUAL];
  wire rx_manual = ctrl_ff[`TRS_CTRL_RX_MANUAL];
  wire seq_en = ctrl_ff[`TRS_CTRL_SEQ_EN];
  // Per-channel status gathered as plain nets. A function that reads module state
  // would not wake a continuous assignment when that state changes.
  wire [NUM_CH-1:0] lock_v;
  wire [NUM_CH-1:0] rxb_v;
  wire [NUM_CH-1:0] txb_v;
  wire [NUM_CH-1:0] txa_v;
  wire [NUM_CH-1:0] rxa_v;
  wire [NUM_CH-1:0] txd_v;
  wire [NUM_CH-1:0] rxd_v;
  wire all_lock = &lock_v;
  wire all_rx_busy = |rxb_v;

  logic [NUM_CH-1:0] tx_lock_seen_ff;
  logic [NUM_CH-1:0] tx_hold_ff;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign cs[c] = '{tx_busy: sync_ff[6*NUM_CH+c], rx_busy: sync_ff[5*NUM_CH+c],
      data_lock: sync_ff[4*NUM_CH+c], tx_ana_ack: sync_ff[3*NUM_CH+c],
      rx_ana_ack: sync_ff[2*NUM_CH+c], tx_dig_ack: sync_ff[NUM_CH+c],
      rx_dig_ack: sync_ff[c]};
    assign lock_v[c] = cs[c].data_lock;
    assign rxb_v[c] = cs[c].rx_busy;
    assign txb_v[c] = cs[c].tx_busy;
    assign txa_v[c] = cs[c].tx_ana_ack;
    assign rxa_v[c] = cs[c].rx_ana_ack;
    assign txd_v[c] = cs[c].tx_dig_ack;
    assign rxd_v[c] = cs[c].rx_dig_ack;
    localparam int SI = TX_SEP ? c : 0;
    // Select is already synchronous; an index past the last PLL reads unlocked.
    wire [SEL_W-1:0] sel = pll_select[SI*SEL_W +: SEL_W];
    wire ch_lock = (int'(sel) < NUM_PLL) ? s_lock[sel] : 1'b0;
    wire tx_busy_c = TX_SEP ? cs[c].tx_busy : |txb_v;
    wire rx_busy_c = RX_SEP ? cs[c].rx_busy : all_rx_busy;
    wire lock_c = RX_SEP ? cs[c].data_lock : all_lock;
    wire tx_hold = sw_rst || any_pll_busy || tx_busy_c || !tx_lock_seen_ff[c] ||
      (!ch_lock && !tx_manual);
    wire tx_ana_hold = sw_rst || tx_busy_c;
    wire rx_ana_hold = sw_rst || rx_busy_c;
    wire rx_hold = rx_ana_hold || rx_analogreset[c] || (!lock_c && !rx_manual) ||
      (seq_en && cs[c].tx_dig_ack);

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        tx_lock_seen_ff[c] <= 1'b0;
        tx_hold_ff[c] <= 1'b1;
      end else begin
        // Initial lock is re-armed by a software reset.
        tx_lock_seen_ff[c] <= sw_rst ? 1'b0 : (tx_lock_seen_ff[c] | ch_lock);
        tx_hold_ff[c] <= tx_hold;
      end
    end

    trs_rst_cnt #(.CYC(TX_DIG_CYC), .CW(CW)) u_txd (
      .core_clk(core_clk), .rst_b(rst_b), .hold(tx_hold), .rst_out(tx_digitalreset[c]),
      .ready(tx_ready[c]));
    trs_rst_cnt #(.CYC(RX_DIG_CYC), .CW(CW)) u_rxd (
      .core_clk(core_clk), .rst_b(rst_b), .hold(rx_hold), .rst_out(rx_digitalreset[c]),
      .ready(rx_ready[c]));
    trs_rst_cnt #(.CYC(`TRS_CYC(`TRS_TX_ANA_NS)), .CW(CW)) u_txa (
      .core_clk(core_clk), .rst_b(rst_b), .hold(tx_ana_hold), .rst_out(tx_analogreset[c]),
      .ready());
    trs_rst_cnt #(.CYC(`TRS_CYC(`TRS_RX_ANA_NS)), .CW(CW)) u_rxa (
      .core_clk(core_clk), .rst_b(rst_b), .hold(rx_ana_hold), .rst_out(rx_analogreset[c]),
      .ready());
  end

  wire [31:0] ack_word = {8'(rxd_v), 8'(txd_v), 8'(rxa_v), 8'(txa_v)};

  // Wishbone decode; one-cycle ack answers every address.
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire hit_ctrl = wb_adr_i == `TRS_ADR_CTRL;
  wire hit_tx = wb_adr_i == `TRS_ADR_TX_STAT;
  wire hit_rx = wb_adr_i == `TRS_ADR_RX_STAT;
  wire hit_ack = wb_adr_i == `TRS_ADR_ACK_STAT;
  wire [31:0] tx_word = {8'h00, 8'(tx_hold_ff), 8'(tx_ready), 8'(tx_digitalreset)};
  wire [31:0] rx_word = {8'h00, 8'(lock_v), 8'(rx_ready), 8'(rx_digitalreset)};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_ff : hit_tx ? tx_word : hit_rx ? rx_word :
    hit_ack ? ack_word : `TRS_UNMAPPED_DATA;
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
    {8{wb_sel_i[0]}}};
  wire [31:0] ctrl_wr = (ctrl_ff & ~byte_mask) | (wb_dat_i & byte_mask & 32'h0000_000f);
  wire [31:0] nxt_ctrl = (wb_req && wb_we_i && hit_ctrl) ? ctrl_wr : ctrl_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `TRS_CTRL_RESET;
      ack_ff <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ack_ff <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
    end
  end
  assign wb_ack_o = ack_ff;
endmodule

// Holds a reset while its cause stands, then counts CYC cycles before release.
module trs_rst_cnt #(
  parameter int CYC = 1,
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hold,
  output logic rst_out,
  output logic ready
);
  import trs_pkg::*;
  trs_state_t st_ff;
  logic [CW-1:0] cnt_ff;
  logic [1:0] rdy_cnt_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= TRS_ST_HOLD;
      cnt_ff <= '0;
      rdy_cnt_ff <= '0;
    end else if (hold) begin
      st_ff <= TRS_ST_HOLD;
      cnt_ff <= '0;
      rdy_cnt_ff <= '0;
    end else begin
      case (st_ff)
        TRS_ST_HOLD: begin
          st_ff <= TRS_ST_COUNT;
          cnt_ff <= CW'(1);
        end
        TRS_ST_COUNT: begin
          if (cnt_ff >= CW'(CYC)) st_ff <= TRS_ST_READY;
          else cnt_ff <= cnt_ff + CW'(1);
        end
        default: begin
          if (rdy_cnt_ff != 2'(`TRS_READY_DLY)) rdy_cnt_ff <= rdy_cnt_ff + 2'h1;
        end
      endcase
    end
  end
  assign rst_out = st_ff != TRS_ST_READY;
  assign ready = (st_ff == TRS_ST_READY) && (rdy_cnt_ff == 2'(`TRS_READY_DLY));
endmodule

// ==== verification/trs_seq_assertions.sv ====
`timescale 1ns/1ns
module trs_seq_assertions #(
  parameter int NUM_CH = 2,
  parameter int NUM_PLL = 2,
  parameter int SEL_N = 2,
  parameter int SEL_W = 1
) (
  // Clock, reset and bus handshake.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Status in, resets and ready flags out.
  input wire logic [NUM_PLL-1:0] pll_locked,
  input wire logic [SEL_N*SEL_W-1:0] pll_select,
  input wire logic [NUM_CH-1:0] tx_cal_busy,
  input wire logic [NUM_CH-1:0] rx_cal_busy,
  input wire logic [NUM_CH-1:0] cdr_data_lock_in,
  input wire logic [NUM_CH-1:0] tx_digitalreset,
  input wire logic [NUM_CH-1:0] rx_digitalreset,
  input wire logic [NUM_CH-1:0] tx_ready,
  input wire logic [NUM_CH-1:0] rx_ready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_tx_busy_hold: assert property (tx_cal_busy[0] [*5] |-> tx_digitalreset[0])
    else $error("tx reset released while tx busy");
  a_rx_busy_hold: assert property (rx_cal_busy[0] [*5] |-> rx_digitalreset[0])
    else $error("rx reset released while rx busy");
  a_pll_lock_sel: assert property ((!pll_locked[pll_select[SEL_W-1:0]] &&
    $stable(pll_select)) [*5] |-> tx_digitalreset[0])
    else $error("tx reset released without selected lock");
  a_cdr_lock_hold: assert property ((!cdr_data_lock_in[0]) [*5] |-> rx_digitalreset[0])
    else $error("rx reset released without data lock");
  a_tx_ready_clean: assert property (!(|(tx_ready & tx_digitalreset)))
    else $error("tx ready while tx reset");
  a_rx_ready_clean: assert property (!(|(rx_ready & rx_digitalreset)))
    else $error("rx ready while rx reset");
  a_sync_lag: assert property ($rose(tx_cal_busy[0]) && tx_ready[0] |-> ##2 tx_ready[0])
    else $error("busy acted before synchroniser delay");
endmodule

bind trs_seq trs_seq_assertions #(.NUM_CH(NUM_CH), .NUM_PLL(NUM_PLL), .SEL_N(SEL_N),
  .SEL_W(SEL_W)) i_trs_seq_assertions (.core_clk(core_clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pll_locked(pll_locked),
  .pll_select(pll_select), .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy),
  .cdr_data_lock_in(cdr_data_lock_in), .tx_digitalreset(tx_digitalreset),
  .rx_digitalreset(rx_digitalreset), .tx_ready(tx_ready), .rx_ready(rx_ready));

// ==== verification/trs_phy_model.sv ====
`timescale 1ns/1ns
module trs_phy_model #(
  parameter int NUM_CH = 2,
  parameter int NUM_PLL = 2,
  parameter int CAL_CYC = 6
) (
  // Bench commands.
  input wire logic core_clk,
  input wire logic [NUM_CH-1:0] cal_go,
  input wire logic [NUM_PLL-1:0] lock_cmd,
  input wire logic pll_cal_cmd,
  input wire logic [NUM_CH-1:0] cdr_cmd,
  // Resets in and status out, tx analog in the low bits, then rx analog, tx and rx digital.
  input wire logic [4*NUM_CH-1:0] rst_vec,
  output logic [4*NUM_CH-1:0] ack_vec,
  output logic [NUM_PLL-1:0] pll_locked,
  output logic [NUM_PLL-1:0] pll_cal_busy,
  output logic [NUM_CH-1:0] tx_cal_busy,
  output logic [NUM_CH-1:0] rx_cal_busy,
  output logic [NUM_CH-1:0] cdr_data_lock_in
);
  int cnt_ff [NUM_CH] = '{default: 0};
  initial ack_vec = '0;
  // Acknowledges trail the resets by a cycle, as a real PHY never answers at once.
  always @(posedge core_clk) begin
    ack_vec <= rst_vec;
    for (int c = 0; c < NUM_CH; c++) begin
      if (cal_go[c]) cnt_ff[c] <= CAL_CYC;
      else if (cnt_ff[c] != 0) cnt_ff[c] <= cnt_ff[c] - 1;
    end
  end
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      rx_cal_busy[c] = cnt_ff[c] != 0;
      tx_cal_busy[c] = rx_cal_busy[c] | (|pll_cal_busy);
    end
  end
  assign pll_cal_busy = {NUM_PLL{pll_cal_cmd}};
  assign pll_locked = lock_cmd & ~pll_cal_busy;
  // The CDR cannot hold data lock while its analog side is in reset.
  assign cdr_data_lock_in = cdr_cmd & ~rx_cal_busy & ~rst_vec[NUM_CH +: NUM_CH];
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`include "trs_cfg.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] sel = 2'h0, cal_go = 2'h0, lock_cmd = 2'h0, cdr_cmd = 2'h0;
  logic pll_cal_cmd = 1'b1;
  logic wb_ack_o;
  logic [31:0] wb_dat_o, rd;
  logic [1:0] lk, pcb, tcb, rcb, cdr, tar, tdr, rar, rdr, txr, rxr;
  logic [7:0] ack;
  int seed = 51264;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  trs_seq #(.TX_DIG_CYC(2), .RX_DIG_CYC(2)) i_trs_seq (.core_clk(core_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pll_locked(lk), .pll_cal_busy(pcb), .pll_select(sel), .tx_cal_busy(tcb),
    .rx_cal_busy(rcb), .cdr_data_lock_in(cdr), .tx_analogreset_stat(ack[1:0]),
    .rx_analogreset_stat(ack[3:2]), .tx_digitalreset_stat(ack[5:4]),
    .rx_digitalreset_stat(ack[7:6]), .tx_analogreset(tar), .tx_digitalreset(tdr),
    .rx_analogreset(rar), .rx_digitalreset(rdr), .tx_ready(txr), .rx_ready(rxr));
  trs_phy_model i_trs_phy_model (.core_clk(core_clk), .cal_go(cal_go), .lock_cmd(lock_cmd),
    .pll_cal_cmd(pll_cal_cmd), .cdr_cmd(cdr_cmd), .rst_vec({rdr, tdr, rar, tar}),
    .ack_vec(ack), .pll_locked(lk), .pll_cal_busy(pcb), .tx_cal_busy(tcb),
    .rx_cal_busy(rcb), .cdr_data_lock_in(cdr));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic logic [1:0] exp_tx(input logic [1:0] s, input logic [1:0] l);
    exp_tx = {~l[s[1]], ~l[s[0]]};
  endfunction
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, `TRS_ADR_CTRL, 32'h0);
    check("ctrl reset", `TRS_CTRL_RESET, rd);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped read", `TRS_UNMAPPED_DATA, rd);
    wb(1'b1, 8'h10, 32'hffff_ffff);
    check("sw reset tx", 32'h3, 32'(tdr));
    $display("test registers done");
    lock_cmd <= 2'b11;
    cdr_cmd <= 2'b11;
    cal_go <= 2'b11;
    wb(1'b1, `TRS_ADR_CTRL, 32'h0);
    repeat (6) @(posedge core_clk);
    check("busy tx", 32'h3, 32'(tdr));
    check("busy rx", 32'h3, 32'(rdr));
    check("busy tx ana", 32'h3, 32'(tar));
    check("busy rx ana", 32'h3, 32'(rar));
    wb(1'b0, `TRS_ADR_ACK_STAT, 32'h0);
    check("acks in reset", 32'h0303_0303, rd);
    pll_cal_cmd <= 1'b0;
    cal_go <= 2'b00;
    repeat (60) if (txr !== 2'b11 || rxr !== 2'b11) @(posedge core_clk);
    check("tx ready", 32'h3, 32'(txr));
    check("rx ready", 32'h3, 32'(rxr));
    check("tx ana free", 32'h0, 32'(tar));
    check("rx ana free", 32'h0, 32'(rar));
    wb(1'b0, `TRS_ADR_ACK_STAT, 32'h0);
    check("acks done", 32'h0, rd);
    $display("test bring up done");
    for (int i = 0; i < 16; i++) begin
      sel <= 2'($random(seed));
      lock_cmd <= 2'($random(seed));
      cdr_cmd <= 2'($random(seed));
      repeat (24) @(posedge core_clk);
      check("lock tx", 32'(exp_tx(sel, lock_cmd)), 32'(tdr));
      check("lock ready", 32'(2'(~exp_tx(sel, lock_cmd))), 32'(txr));
      check("cdr rx", 32'(2'(~cdr_cmd)), 32'(rdr));
      cal_go <= 2'($random(seed));
      repeat (6) @(posedge core_clk);
      check("cal tx", 32'(cal_go | exp_tx(sel, lock_cmd)), 32'(tdr));
      check("cal rx", 32'(cal_go | 2'(~cdr_cmd)), 32'(rdr));
      cal_go <= 2'b00;
    end
    $display("test random done");
    final_report();
  end
endmodule
